// >>> hdl/spi_frame_defines.vh
// constants for the frame and enable control slice
`ifndef SPI_FRAME_DEFINES_VH
`define SPI_FRAME_DEFINES_VH

`define ADDR_W            24
`define ADDR_TX_FRAME_CMD 24'hffe261
`define ADDR_PORT_CONTROL 24'hffe262
`define ADDR_SLICE_STATUS 24'hffe26e
`define ADDR_LINK_CONFIG  24'hffe26f

`define TX_FRAME_CMD_RST  8'h00
`define PORT_CONTROL_RST  8'h00
`define LINK_CONFIG_RST   8'h00

`define TFC_SEL_LEVEL     0
`define TFC_FRAME_LAST    1

`define CTL_ENABLE_LOW    0
`define CTL_MASTER_SEL    1
`define CTL_WIRED_OR      2
`define CTL_CLK_POL       3
`define CTL_PHASE         4
`define CTL_RATE_GEN      5
`define CTL_ENABLE_HIGH   6
`define CTL_DATA_IRQ      7

`define CFG_SEL_OUT_EN    0

`define DIR_DISABLED      2'b00
`define DIR_RX_ONLY       2'b01
`define DIR_TX_ONLY       2'b10
`define DIR_TX_RX         2'b11

`define ALL_ONES_CHAR     8'hff
`define CHAR_BITS         8
`define FIFO_DEPTH        8

`endif

// >>> hdl/sync2.v
// two-stage synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter WIDTH = 1
) (
   input  wire             mclk,
   input  wire             reset_n,
   input  wire [WIDTH-1:0] d_in,
   output reg  [WIDTH-1:0] q_out
);
   reg [WIDTH-1:0] meta_r;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= {WIDTH{1'b0}};
         q_out  <= {WIDTH{1'b0}};
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/byte_fifo.v
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             mclk,
   input  wire             reset_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   output reg  [AW:0]      level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_r;
   reg [AW-1:0]    rd_ptr_r;
   wire            push;
   wire            pop;

   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         level    <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push & !pop) begin
            level <= level + 1'b1;
         end else if (pop & !push) begin
            level <= level - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> hdl/spi_frame_ctrl.v
// frame, select and enable/direction control of the serial peripheral port
// Overview of operation
// - master: after frame-last byte shifts out, toggle select and clear frame-last.
// - frame-last and select level set by cpu write or by dma inputs.
// - with select output enabled in master mode, select level bit drives the select pin.
// - tx frame command bits 7:2 read zero; register resets to zero.
// - control register bit order fixed; all bits read/write, reset zero.
// - data irq enable low: no tx-empty/rx-full irq, errors still interrupt.
// - data irq enable high: tx-empty and rx-full also interrupt.
// - data irq enable never masks error interrupts.
// - enable/direction code is control bit 6 high, bit 0 low.
// - code 00 disables port; rate generator timer when rate control set.
// - receive-only: tx-empty asserts, no tx irq or tx dma request.
// - receive-only slave shifts out all-ones characters.
// - transmit-only: rx-full asserts, no rx irq or rx dma request.
// - transmit/receive: both flags, irqs and dma requests active.
// - dma requests on tx-empty and rx-full; acknowledges accepted.
// - dma select level high sets the select bit with first byte; dma eof sets frame-last.
`timescale 1ns/1ps
`default_nettype none
`include "spi_frame_defines.vh"
module spi_frame_ctrl #(
   parameter CHAR_BITS  = `CHAR_BITS,
   parameter FIFO_DEPTH = `FIFO_DEPTH
) (
   input  wire                mclk,
   input  wire                reset_n,
   input  wire [`ADDR_W-1:0]  reg_addr,
   input  wire [7:0]          reg_wdata,
   input  wire                reg_wr,
   input  wire                reg_rd,
   output reg  [7:0]          reg_rdata,
   input  wire                sck_pin,
   input  wire                tx_empty_flag,
   input  wire                rx_full_flag,
   input  wire                tx_underrun_flag,
   input  wire                collision_flag,
   input  wire                slave_abort_flag,
   input  wire                rx_overrun_flag,
   input  wire                rate_gen_timeout,
   input  wire                shift_start,
   input  wire                dma_tx_ack,
   input  wire [7:0]          dma_tx_data,
   input  wire                dma_tx_first,
   input  wire                dma_tx_sel_level,
   input  wire                dma_tx_eof,
   input  wire                dma_rx_ack,
   output reg                 dma_tx_req,
   output reg                 dma_rx_req,
   output reg                 tx_load,
   output reg  [7:0]          tx_load_data,
   output reg                 select_out,
   output reg                 select_oe,
   output reg                 irq,
   output reg  [7:0]          port_control_q,
   output reg                 rate_gen_timer_en
);
   localparam ST_IDLE  = 1'b0;
   localparam ST_SHIFT = 1'b1;
   localparam FW       = 10;
   localparam CW       = 4;

   reg              frame_last_flag_r;
   reg              frame_last_flag_nxt;
   reg              select_level_bit_r;
   reg              select_level_bit_nxt;
   reg              select_output_enable_r;
   reg              st_r;
   reg              st_nxt;
   reg  [CW-1:0]    bit_cnt_r;
   reg  [CW-1:0]    bit_cnt_nxt;
   reg              sck_prev_r;
   reg              tx_ack_pend_r;
   reg              rx_ack_pend_r;
   reg              tx_empty_prev_r;
   reg              rx_full_prev_r;
   reg              frame_done;
   wire             sck_sync;
   wire [1:0]       dir_code;
   wire             tx_path;
   wire             rx_path;
   wire             master_mode;
   wire             clk_pol;
   wire             idle_edge;
   wire             fifo_in_ready;
   wire             fifo_out_valid;
   wire             fifo_out_ready;
   wire [FW-1:0]    fifo_out_data;
   wire [3:0]       fifo_level;
   wire             pop;
   wire             wr_tfc;
   wire             wr_ctl;
   wire             wr_cfg;
   wire             err_any;
   wire             data_irq;

   // register write decode
   assign wr_tfc = reg_wr & (reg_addr == `ADDR_TX_FRAME_CMD);
   assign wr_ctl = reg_wr & (reg_addr == `ADDR_PORT_CONTROL);
   assign wr_cfg = reg_wr & (reg_addr == `ADDR_LINK_CONFIG);

   // enable and direction decode
   assign dir_code    = {port_control_q[`CTL_ENABLE_HIGH],
                         port_control_q[`CTL_ENABLE_LOW]};
   assign tx_path     = dir_code[1];
   assign rx_path     = dir_code[0];
   assign master_mode = port_control_q[`CTL_MASTER_SEL];
   assign clk_pol     = port_control_q[`CTL_CLK_POL];

   // link clock sampled into the system domain
   sync2 #(
      .WIDTH (1)
   ) u_sck_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .d_in    (sck_pin),
      .q_out   (sck_sync)
   );

   // an edge back to the idle level closes one bit
   assign idle_edge = (sck_sync != sck_prev_r) & (sck_sync == clk_pol);

   // dma transmit bytes wait here for the shifter
   byte_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH),
      .AW    (3)
   ) u_tx_fifo (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_valid  (dma_tx_ack),
      .in_ready  (fifo_in_ready),
      .in_data   ({dma_tx_eof, dma_tx_first & dma_tx_sel_level, dma_tx_data}),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   // shifter takes a byte only when idle and its buffer is empty
   assign fifo_out_ready = (st_r == ST_IDLE) & tx_empty_flag & tx_path;
   assign pop            = fifo_out_valid & fifo_out_ready;

   // byte tracking on the link clock edges
   always @* begin
      st_nxt      = st_r;
      bit_cnt_nxt = bit_cnt_r;
      frame_done  = 1'b0;
      case (st_r)
         ST_IDLE: begin
            if (pop | shift_start) begin
               st_nxt      = ST_SHIFT;
               bit_cnt_nxt = {CW{1'b0}};
            end
         end
         ST_SHIFT: begin
            if (idle_edge) begin
               if (bit_cnt_r == CHAR_BITS[CW-1:0] - 1'b1) begin
                  st_nxt     = ST_IDLE;
                  frame_done = 1'b1;
               end else begin
                  bit_cnt_nxt = bit_cnt_r + 1'b1;
               end
            end
         end
         default: begin
            st_nxt      = ST_IDLE;
            bit_cnt_nxt = {CW{1'b0}};
         end
      endcase
   end

   // frame-last and select level update, set wins over auto clear
   always @* begin
      frame_last_flag_nxt  = frame_last_flag_r;
      select_level_bit_nxt = select_level_bit_r;
      if (frame_done & master_mode & frame_last_flag_r) begin
         frame_last_flag_nxt  = 1'b0;
         select_level_bit_nxt = ~select_level_bit_r;
      end
      if (wr_tfc) begin
         frame_last_flag_nxt  = reg_wdata[`TFC_FRAME_LAST];
         select_level_bit_nxt = reg_wdata[`TFC_SEL_LEVEL];
      end
      if (pop) begin
         if (fifo_out_data[8]) begin
            select_level_bit_nxt = 1'b1;
         end else if (fifo_out_data[9] == 1'b0 && select_level_bit_nxt == 1'b1 &&
                      1'b0) begin
            select_level_bit_nxt = 1'b0;
         end
         if (fifo_out_data[9]) begin
            frame_last_flag_nxt = 1'b1;
         end
      end
   end

   assign err_any  = tx_underrun_flag | collision_flag |
                     slave_abort_flag | rx_overrun_flag;
   assign data_irq = port_control_q[`CTL_DATA_IRQ] &
                     ((tx_empty_flag & tx_path) |
                      (rx_full_flag & rx_path));

   // state, registers and outputs
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         frame_last_flag_r      <= 1'b0;
         select_level_bit_r     <= 1'b0;
         select_output_enable_r <= 1'b0;
         port_control_q         <= `PORT_CONTROL_RST;
         st_r                   <= ST_IDLE;
         bit_cnt_r              <= {CW{1'b0}};
         sck_prev_r             <= 1'b0;
         tx_ack_pend_r          <= 1'b0;
         rx_ack_pend_r          <= 1'b0;
         tx_empty_prev_r        <= 1'b0;
         rx_full_prev_r         <= 1'b0;
         dma_tx_req             <= 1'b0;
         dma_rx_req             <= 1'b0;
         tx_load                <= 1'b0;
         tx_load_data           <= 8'h00;
         select_out             <= 1'b1;
         select_oe              <= 1'b0;
         irq                    <= 1'b0;
         rate_gen_timer_en      <= 1'b0;
         reg_rdata              <= 8'h00;
      end else begin
         frame_last_flag_r  <= frame_last_flag_nxt;
         select_level_bit_r <= select_level_bit_nxt;
         st_r               <= st_nxt;
         bit_cnt_r          <= bit_cnt_nxt;
         sck_prev_r         <= sck_sync;
         tx_empty_prev_r    <= tx_empty_flag;
         rx_full_prev_r     <= rx_full_flag;
         if (wr_ctl) begin
            port_control_q <= reg_wdata;
         end
         if (wr_cfg) begin
            select_output_enable_r <= reg_wdata[`CFG_SEL_OUT_EN];
         end

         // select pin follows the bit in the same cycle as any change while select output is enabled, else held high
         if (select_output_enable_r) begin
            select_out <= select_level_bit_nxt;
         end else begin
            select_out <= 1'b1;
         end
         select_oe <= select_output_enable_r & master_mode;

         // byte handed to the shifter
         tx_load <= pop;
         if (pop) begin
            if (dir_code == `DIR_RX_ONLY && !master_mode) begin
               tx_load_data <= `ALL_ONES_CHAR;
            end else begin
               tx_load_data <= fifo_out_data[7:0];
            end
         end else if (shift_start && dir_code == `DIR_RX_ONLY && !master_mode) begin
            tx_load_data <= `ALL_ONES_CHAR;
         end

         // transmit dma request, held off by ack until tx-empty re-asserts
         if (dma_tx_ack) begin
            tx_ack_pend_r <= 1'b1;
         end else if (tx_empty_flag & !tx_empty_prev_r) begin
            tx_ack_pend_r <= 1'b0;
         end
         dma_tx_req <= tx_path & tx_empty_flag & fifo_in_ready &
                       !dma_tx_ack & !tx_ack_pend_r;

         // receive dma request, held off by ack until rx-full falls
         if (dma_rx_ack) begin
            rx_ack_pend_r <= 1'b1;
         end else if (!rx_full_flag & rx_full_prev_r) begin
            rx_ack_pend_r <= 1'b0;
         end
         dma_rx_req <= rx_path & rx_full_flag &
                       !dma_rx_ack & !rx_ack_pend_r;

         // interrupt line: data gated, errors never, timer when disabled
         rate_gen_timer_en <= (dir_code == `DIR_DISABLED) &
                              port_control_q[`CTL_RATE_GEN];
         irq <= data_irq | err_any |
                (rate_gen_timer_en & rate_gen_timeout);

         // read data stands one cycle only
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `ADDR_TX_FRAME_CMD:
                  reg_rdata <= {6'h00, frame_last_flag_r, select_level_bit_r};
               `ADDR_PORT_CONTROL:
                  reg_rdata <= port_control_q;
               `ADDR_LINK_CONFIG:
                  reg_rdata <= {7'h00, select_output_enable_r};
               `ADDR_SLICE_STATUS:
                  reg_rdata <= {fifo_level, tx_ack_pend_r, rx_ack_pend_r,
                                fifo_in_ready, st_r};
               default:
                  reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/spi_frame_ctrl_properties.sv
// concurrent checks on the ports of the frame and enable control slice
`timescale 1ns/1ps
`default_nettype none
`include "spi_frame_defines.vh"
module spi_frame_ctrl_properties (
   input wire logic               mclk,
   input wire logic               reset_n,
   input wire logic [`ADDR_W-1:0] reg_addr,
   input wire logic [7:0]         reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [7:0]         reg_rdata,
   input wire logic               tx_empty_flag,
   input wire logic               rx_full_flag,
   input wire logic               tx_underrun_flag,
   input wire logic               collision_flag,
   input wire logic               slave_abort_flag,
   input wire logic               rx_overrun_flag,
   input wire logic               rate_gen_timeout,
   input wire logic               dma_tx_req,
   input wire logic               dma_rx_req,
   input wire logic               tx_load,
   input wire logic               select_out,
   input wire logic               select_oe,
   input wire logic               irq,
   input wire logic [7:0]         port_control_q,
   input wire logic               rate_gen_timer_en
);
   wire       errs;
   wire [7:0] q;
   assign errs = tx_underrun_flag | collision_flag | slave_abort_flag | rx_overrun_flag;
   assign q    = port_control_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_tfc_reserved_zero: assert property (reg_rd && reg_addr == `ADDR_TX_FRAME_CMD
      |=> reg_rdata[7:2] == 6'h00) else $error("reserved bits read nonzero");
   a_ctl_read_back: assert property (reg_rd && reg_addr == `ADDR_PORT_CONTROL
      |=> reg_rdata == q) else $error("control read differs from register");
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read");
   a_err_irq_raise: assert property (errs |=> irq)
      else $error("error flag gave no interrupt");
   a_data_irq_raise: assert property (q[7] && ((tx_empty_flag && q[6])
      || (rx_full_flag && q[0])) |=> irq) else $error("data flag gave no interrupt");
   a_data_irq_mask: assert property (!q[7] && !errs && !(rate_gen_timer_en
      && rate_gen_timeout) |=> !irq) else $error("masked data flag interrupted");
   a_rx_req_path: assert property (dma_rx_req |-> $past(q[0]) && $past(rx_full_flag))
      else $error("rx request without rx path");
   a_tx_req_path: assert property (dma_tx_req |-> $past(q[6]) && $past(tx_empty_flag))
      else $error("tx request without tx path");
   a_timer_mode_en: assert property ($stable(q)
      |-> rate_gen_timer_en == (q[5] && !q[6] && !q[0])) else $error("timer enable wrong");
   a_sel_write_drive: assert property (select_oe && $stable(select_oe) && reg_wr
      && reg_addr == `ADDR_TX_FRAME_CMD |=> ##1 select_out == $past(reg_wdata[0], 2))
      else $error("select pin does not follow write");
   c_tx_load: cover property (tx_load);
   c_irq_rise: cover property ($rose(irq));
   c_rx_req: cover property (dma_rx_req);
endmodule
bind spi_frame_ctrl spi_frame_ctrl_properties chk (.mclk(mclk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag),
   .tx_underrun_flag(tx_underrun_flag), .collision_flag(collision_flag),
   .slave_abort_flag(slave_abort_flag), .rx_overrun_flag(rx_overrun_flag),
   .rate_gen_timeout(rate_gen_timeout), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req),
   .tx_load(tx_load), .select_out(select_out), .select_oe(select_oe), .irq(irq),
   .port_control_q(port_control_q), .rate_gen_timer_en(rate_gen_timer_en));
`default_nettype wire

// >>> bench/link_partner.sv
// serial clock source on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module link_partner #(
   parameter HALF = 80
) (
   input  wire logic pol,
   input  wire logic go,
   output wire logic sck_pin,
   output var  logic busy
);
   logic clk_r;
   // idle level outside frames
   assign sck_pin = busy ? clk_r : pol;
   initial begin
      busy = 1'b0;
      clk_r = 1'b0;
   end
   // eight bit times, starting 7 ns after go rises
   always @(posedge go) begin
      busy = 1'b1;
      clk_r = pol;
      #7;
      repeat (8) begin
         #HALF clk_r = !pol;
         #HALF clk_r = pol;
      end
      busy = 1'b0;
   end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the frame and enable control slice
`timescale 1ns/1ps
`default_nettype none
`include "spi_frame_defines.vh"
module tb;
   localparam logic [23:0] tfc_a = `ADDR_TX_FRAME_CMD;
   localparam logic [23:0] ctl_a = `ADDR_PORT_CONTROL;
   localparam logic [23:0] cfg_a = `ADDR_LINK_CONFIG;
   logic        mclk, reset_n, reg_wr, reg_rd, sck_pin, tx_empty_flag, rx_full_flag;
   logic        tx_underrun_flag, collision_flag, slave_abort_flag, rx_overrun_flag;
   logic        rate_gen_timeout, shift_start, dma_tx_ack, dma_tx_first, dma_tx_sel_level;
   logic        dma_tx_eof, dma_rx_ack, dma_tx_req, dma_rx_req, tx_load, select_out;
   logic        select_oe, irq, rate_gen_timer_en, go, busy, rd_seen;
   logic [23:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, dma_tx_data, tx_load_data, port_control_q, r;
   logic [7:0]  rq[$], lq[$];
   int          fail_count, n_checks, m;
   spi_frame_ctrl uut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sck_pin(sck_pin), .tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag),
      .tx_underrun_flag(tx_underrun_flag), .collision_flag(collision_flag),
      .slave_abort_flag(slave_abort_flag), .rx_overrun_flag(rx_overrun_flag),
      .rate_gen_timeout(rate_gen_timeout), .shift_start(shift_start),
      .dma_tx_ack(dma_tx_ack), .dma_tx_data(dma_tx_data), .dma_tx_first(dma_tx_first),
      .dma_tx_sel_level(dma_tx_sel_level), .dma_tx_eof(dma_tx_eof), .dma_rx_ack(dma_rx_ack),
      .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .tx_load(tx_load),
      .tx_load_data(tx_load_data), .select_out(select_out), .select_oe(select_oe),
      .irq(irq), .port_control_q(port_control_q), .rate_gen_timer_en(rate_gen_timer_en));
   link_partner sck_src (.pol(port_control_q[3]), .go(go), .sck_pin(sck_pin), .busy(busy));
   always #10 mclk = ~mclk;
   task automatic summarize();
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic timeout();
      fail_count++;
      $display("ERROR %0t: wait ran out", $time);
      summarize();
   endtask
   task automatic check1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: bit got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: byte got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [23:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      rq.push_back(exp);
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask
   task automatic push(input logic [7:0] d, input logic f, input logic e);
      @(posedge mclk);
      dma_tx_ack <= 1'b1;
      dma_tx_data <= d;
      dma_tx_first <= f;
      dma_tx_sel_level <= 1'b1;
      dma_tx_eof <= e;
      lq.push_back(d);
      @(posedge mclk);
      dma_tx_ack <= 1'b0;
   endtask
   task automatic wait_load();
      int i;
      for (i = 0; i < 200 && tx_load !== 1'b1; i++)
         @(posedge mclk);
      if (tx_load !== 1'b1)
         timeout();
   endtask
   task automatic frame();
      int i;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      for (i = 0; i < 200 && busy; i++)
         @(posedge mclk);
      if (busy)
         timeout();
      repeat (8) @(posedge mclk);
   endtask
   // result monitor: read data and shifter loads
   always @(posedge mclk) begin
      if (rd_seen)
         cmp8(reg_rdata, rq.pop_front());
      if (tx_load === 1'b1)
         cmp8(tx_load_data, lq.pop_front());
      rd_seen <= reg_rd;
   end
   initial begin
      {mclk, reset_n, reg_wr, reg_rd, tx_empty_flag, rx_full_flag, go, rd_seen} = 8'h00;
      {tx_underrun_flag, collision_flag, slave_abort_flag, rx_overrun_flag} = 4'h0;
      {rate_gen_timeout, shift_start, dma_tx_ack, dma_tx_first} = 4'h0;
      {dma_tx_sel_level, dma_tx_eof, dma_rx_ack} = 3'h0;
      {reg_addr, reg_wdata, dma_tx_data} = 40'h0;
      fail_count = 0;
      n_checks = 0;
      void'($urandom(32'h1764));
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      rd(tfc_a, 8'h00);
      rd(ctl_a, 8'h00);
      rd(24'hffe263, 8'h00);
      for (m = 0; m < 4; m++) begin
         r = 8'($urandom);
         wr(ctl_a, r);
         rd(ctl_a, r);
      end
      wr(tfc_a, 8'hff);
      rd(tfc_a, 8'h03);
      wr(cfg_a, 8'h01);
      wr(ctl_a, 8'h02);
      for (m = 0; m < 2; m++) begin
         wr(tfc_a, 8'(m));
         repeat (2) @(posedge mclk);
         check1(select_out, m[0]);
         check1(select_oe, 1'b1);
      end
      for (m = 0; m < 8; m++) begin
         wr(ctl_a, {m[2], m[1], 5'h00, m[0]});
         tx_empty_flag <= 1'b1;
         rx_full_flag <= 1'b0;
         repeat (3) @(posedge mclk);
         check1(irq, m[2] & m[1]);
         check1(dma_tx_req, m[1]);
         tx_empty_flag <= 1'b0;
         rx_full_flag <= 1'b1;
         repeat (3) @(posedge mclk);
         check1(irq, m[2] & m[0]);
         check1(dma_rx_req, m[0]);
      end
      dma_rx_ack <= 1'b1;
      @(posedge mclk);
      dma_rx_ack <= 1'b0;
      repeat (2) @(posedge mclk);
      check1(dma_rx_req, 1'b0);
      wr(ctl_a, 8'h00);
      rx_full_flag <= 1'b0;
      for (m = 0; m < 4; m++) begin
         {tx_underrun_flag, collision_flag, slave_abort_flag, rx_overrun_flag} <= 4'h1 << m;
         repeat (3) @(posedge mclk);
         check1(irq, 1'b1);
         {tx_underrun_flag, collision_flag, slave_abort_flag, rx_overrun_flag} <= 4'h0;
         repeat (3) @(posedge mclk);
         check1(irq, 1'b0);
      end
      wr(ctl_a, 8'h20);
      repeat (3) @(posedge mclk);
      check1(rate_gen_timer_en, 1'b1);
      rate_gen_timeout <= 1'b1;
      @(posedge mclk);
      rate_gen_timeout <= 1'b0;
      @(posedge mclk);
      check1(irq, 1'b1);
      wr(ctl_a, 8'h21);
      repeat (3) @(posedge mclk);
      check1(rate_gen_timer_en, 1'b0);
      wr(ctl_a, 8'h01);
      shift_start <= 1'b1;
      @(posedge mclk);
      shift_start <= 1'b0;
      @(posedge mclk);
      cmp8(tx_load_data, `ALL_ONES_CHAR);
      frame();
      wr(ctl_a, 8'h03);
      shift_start <= 1'b1;
      @(posedge mclk);
      shift_start <= 1'b0;
      frame();
      wr(ctl_a, 8'h42);
      wr(tfc_a, 8'h00);
      tx_empty_flag <= 1'b1;
      push(8'($urandom), 1'b1, 1'b0);
      push(8'($urandom), 1'b0, 1'b1);
      wait_load();
      rd(tfc_a, 8'h01);
      tx_empty_flag <= 1'b0;
      frame();
      tx_empty_flag <= 1'b1;
      wait_load();
      rd(tfc_a, 8'h03);
      frame();
      rd(tfc_a, 8'h00);
      check1(select_out, 1'b0);
      repeat (3) @(posedge mclk);
      summarize();
   end
endmodule
`default_nettype wire
